// [pin_sync.sv]
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pin side
  input  wire logic pin_in,
  // Filtered level
  output logic      level_out
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  // Three-stage capture, change taken when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff    <= 1'b0;
      s2_ff    <= 1'b0;
      s3_ff    <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign level_out = level_ff;

  agree_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s2_ff == s3_ff) |=> (level_ff == $past(s3_ff)))
    else $error("filtered level missed an agreed change");

endmodule : pin_sync

// [sticky_irq.sv]
`timescale 1ns/1ps
module sticky_irq #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Events and software side
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic             clear_on_read,
  input  wire logic [WIDTH-1:0] mask_in,
  // Status and interrupt
  output logic      [WIDTH-1:0] status_out,
  output logic                  irq
);

  logic [WIDTH-1:0] status_ff;
  logic [WIDTH-1:0] nxt_status;

  // New events win over a clearing read in the same cycle
  assign nxt_status = (clear_on_read ? {WIDTH{1'b0}} : status_ff) | event_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= '0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign status_out = status_ff;
  assign irq        = |(status_ff & mask_in);

  set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (|event_in) && clear_on_read |=> ((status_ff & $past(event_in)) == $past(event_in)))
    else $error("event lost against clearing read");

endmodule : sticky_irq

// [sync_status_pkg.sv]
// How it works
// [R01] Bit 0 of the word at index 0B6h reads 1 while sync evaluation runs, else 0.
// [R02] Bit 7 of the word at index 0B7h reads 1 while the sync state machine is busy.
// [R03] Bit 6 of the word at index 0B7h reads 1 on an internal sync state error, else 0.
// [R04] Bits 3:0 at index 0B7h give the 4-bit machine state; bits 5:4 read as zero.
// [R05] Bit 7 at index 0B8h reads 1 once the reference pulse is found and locked.
// [R06] Bits 3:0 at index 0BAh give the lock counter; bits 7:4 read as zero.
// [R07] Indices 0BBh, 0BCh and 0BDh give delay count, sample enable value and 2-bit phase.
// [R08] Lock is declared only after a programmable 4-bit number of equal period checks.
// [R09] With auto relock on, a lost lock restarts acquisition; with it off, nothing restarts.
// [R10] The adjust delay applied, in clock periods, reads as an 8-bit value.
// [R11] Writes to the sync status words are ignored and leave every value unchanged.
package sync_status_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_ADJ_DELAY  = 10'h0B5;
  localparam logic [9:0] IDX_EVAL       = 10'h0B6;
  localparam logic [9:0] IDX_FSM        = 10'h0B7;
  localparam logic [9:0] IDX_LOCK       = 10'h0B8;
  localparam logic [9:0] IDX_LOCK_COUNTER   = 10'h0BA;
  localparam logic [9:0] IDX_DELAY_COUNTER  = 10'h0BB;
  localparam logic [9:0] IDX_SAMPLE     = 10'h0BC;
  localparam logic [9:0] IDX_PHASE      = 10'h0BD;
  localparam logic [9:0] IDX_CTRL       = 10'h0E0;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0E1;
  localparam logic [9:0] IDX_IRQ_MASK   = 10'h0E2;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          BIT_EVAL       = 0;
  localparam int          BIT_BUSY       = 7;
  localparam int          BIT_STATE_ERR  = 6;
  localparam int          BIT_LOCKED     = 7;
  localparam int          BIT_RELOCK     = 4;
  localparam int          BIT_ENABLE     = 7;
  localparam int          IRQ_WIDTH      = 3;
  localparam int          EVT_LOCK_GAIN  = 0;
  localparam int          EVT_LOCK_LOST  = 1;
  localparam int          EVT_STATE_ERR  = 2;
  localparam logic [3:0]  THRESH_RESET   = 4'h4;
  localparam logic [7:0]  PERIOD_MAX     = 8'hFF;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ---------------------------------------------------------------
  // Sync machine states, Gray along idle-seek-measure-locked
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_SEEK    = 4'h1,
    ST_MEASURE = 4'h3,
    ST_LOCKED  = 4'h2,
    ST_ERROR   = 4'h6
  } sync_state_t;

endpackage : sync_status_pkg

// [sync_status_readback.sv]
`timescale 1ns/1ps
module sync_status_readback #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Reference pulse pin
  input  wire logic              sysref_in,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Interrupt
  output logic                   irq
);

  // ---------------------------------------------------------------
  // Reference pulse capture
  // ---------------------------------------------------------------
  logic sref_lvl;
  logic sref_prev_ff;
  logic sref_edge;

  pin_sync u_pin_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (sysref_in),
    .level_out (sref_lvl)
  );

  // Rising edge of the filtered pulse
  assign sref_edge = sref_lvl && !sref_prev_ff;

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  logic        enable_ff;
  logic        relock_ff;
  logic [3:0]  thresh_ff;
  logic [2:0]  mask_ff;

  // ---------------------------------------------------------------
  // Sync state machine
  // ---------------------------------------------------------------
  sync_status_pkg::sync_state_t state_ff;
  sync_status_pkg::sync_state_t nxt_state;
  logic [7:0]  period_cnt_ff;
  logic [7:0]  last_period_ff;
  logic [7:0]  applied_ff;
  logic [7:0]  sample_ff;
  logic [1:0]  phase_ff;
  logic [3:0]  lock_counter_ff;
  logic [3:0]  nxt_lock_counter;
  logic [4:0]  lock_counter_inc;
  logic        equal_check;
  logic        period_full;
  logic        reach_lock;
  logic        lose_lock;
  logic [2:0]  events;

  // Equal check compares this period with the one before
  assign equal_check  = sref_edge && (period_cnt_ff == last_period_ff);
  assign period_full  = !sref_edge && (period_cnt_ff == sync_status_pkg::PERIOD_MAX);
  assign lock_counter_inc = {1'b0, lock_counter_ff} + 5'h01;
  assign reach_lock   = equal_check && (lock_counter_inc >= {1'b0, thresh_ff}); // see [R08]
  assign lose_lock    = (state_ff == sync_status_pkg::ST_LOCKED) &&
                        ((sref_edge && !equal_check) || period_full);

  // Next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      sync_status_pkg::ST_IDLE: begin
        if (enable_ff) nxt_state = sync_status_pkg::ST_SEEK;
      end
      sync_status_pkg::ST_SEEK: begin
        if (sref_edge) nxt_state = sync_status_pkg::ST_MEASURE;
      end
      sync_status_pkg::ST_MEASURE: begin
        if (period_full) nxt_state = sync_status_pkg::ST_ERROR; // see [R03]
        else if (reach_lock) nxt_state = sync_status_pkg::ST_LOCKED; // see [R08]
      end
      sync_status_pkg::ST_LOCKED: begin
        if (lose_lock) begin
          nxt_state = relock_ff ? sync_status_pkg::ST_SEEK    // see [R09]
                                : sync_status_pkg::ST_ERROR;
        end
      end
      sync_status_pkg::ST_ERROR: begin
        nxt_state = sync_status_pkg::ST_ERROR;
      end
      default: nxt_state = sync_status_pkg::ST_IDLE;
    endcase
    if (!enable_ff) nxt_state = sync_status_pkg::ST_IDLE;
  end

  // Lock counter saturates, restarts on a mismatch
  always_comb begin
    nxt_lock_counter = lock_counter_ff;
    if (state_ff != sync_status_pkg::ST_MEASURE) begin
      nxt_lock_counter = '0;
    end else if (equal_check) begin
      nxt_lock_counter = lock_counter_inc[4] ? lock_counter_ff : lock_counter_inc[3:0];
    end else if (sref_edge) begin
      nxt_lock_counter = '0;
    end
  end

  // Machine registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff    <= sync_status_pkg::ST_IDLE;
      lock_counter_ff <= '0;
    end else begin
      state_ff    <= nxt_state;
      lock_counter_ff <= nxt_lock_counter; // see [R06]
    end
  end

  // Period measure, phase and sample history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sref_prev_ff   <= 1'b0;
      period_cnt_ff  <= '0;
      last_period_ff <= '0;
      sample_ff      <= '0;
      phase_ff       <= '0;
    end else begin
      sref_prev_ff <= sref_lvl;
      sample_ff    <= {sample_ff[6:0], sref_lvl}; // see [R07]
      if (state_ff == sync_status_pkg::ST_IDLE || state_ff == sync_status_pkg::ST_SEEK) begin
        period_cnt_ff  <= '0;
        last_period_ff <= '0;
      end else if (sref_edge) begin
        period_cnt_ff  <= '0;
        last_period_ff <= period_cnt_ff;
        phase_ff       <= period_cnt_ff[1:0]; // see [R07]
      end else if (!period_full) begin
        period_cnt_ff  <= period_cnt_ff + 8'h01; // see [R07]
      end
    end
  end

  // Adjust delay taken when lock is declared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      applied_ff <= '0;
    end else if (state_ff == sync_status_pkg::ST_MEASURE && reach_lock && !period_full) begin
      applied_ff <= period_cnt_ff; // see [R10]
    end
  end

  // Status flags
  logic eval_active_flag;
  logic busy_flag;
  logic state_err_flag;
  logic sysref_locked_flag;

  assign eval_active_flag   = enable_ff && (state_ff != sync_status_pkg::ST_IDLE); // see [R01]
  assign busy_flag          = (state_ff == sync_status_pkg::ST_SEEK) ||
                              (state_ff == sync_status_pkg::ST_MEASURE); // see [R02]
  assign state_err_flag     = (state_ff == sync_status_pkg::ST_ERROR); // see [R03]
  assign sysref_locked_flag = (state_ff == sync_status_pkg::ST_LOCKED); // see [R05]

  // Events for the interrupt bank
  assign events[sync_status_pkg::EVT_LOCK_GAIN] = (nxt_state == sync_status_pkg::ST_LOCKED) &&
                                                  !sysref_locked_flag;
  assign events[sync_status_pkg::EVT_LOCK_LOST] = lose_lock && enable_ff;
  assign events[sync_status_pkg::EVT_STATE_ERR] = (nxt_state == sync_status_pkg::ST_ERROR) &&
                                                  !state_err_flag;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic              aw_held_ff;
  logic              w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0]        wbyte_ff;
  logic              wlane_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       rdata_ff;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_byte;
  logic              wr_lane;
  logic [9:0]        wr_idx;
  logic [9:0]        rd_idx;
  logic              wr_align;
  logic              rd_align;
  logic              wr_ctrl;
  logic              wr_mask;
  logic              wr_known;
  logic              rd_known;
  logic              rd_status_clr;
  logic [7:0]        rd_byte;
  logic [2:0]        irq_status;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign aw_hs    = s_axi_awvalid && s_axi_awready;
  assign w_hs     = s_axi_wvalid && s_axi_wready;
  assign ar_hs    = s_axi_arvalid && s_axi_arready;
  assign do_write = (aw_held_ff || aw_hs) && (w_held_ff || w_hs);

  // Write decode on the address and data as held or just taken
  assign wr_addr  = aw_hs ? s_axi_awaddr : awaddr_ff;
  assign wr_byte  = w_hs ? s_axi_wdata[7:0] : wbyte_ff;
  assign wr_lane  = w_hs ? s_axi_wstrb[0] : wlane_ff;
  assign wr_idx   = wr_addr[11:2];
  assign wr_align = (wr_addr[1:0] == 2'h0);
  assign wr_ctrl  = do_write && wr_align && wr_lane && (wr_idx == sync_status_pkg::IDX_CTRL);
  assign wr_mask  = do_write && wr_align && wr_lane && (wr_idx == sync_status_pkg::IDX_IRQ_MASK);
  // Status words accept the write and drop it
  assign wr_known = wr_align && (((wr_idx >= sync_status_pkg::IDX_ADJ_DELAY) &&
                    (wr_idx <= sync_status_pkg::IDX_PHASE) &&
                    (wr_idx != 10'h0B9)) || (wr_idx == sync_status_pkg::IDX_CTRL) ||
                    (wr_idx == sync_status_pkg::IDX_IRQ_STATUS) ||
                    (wr_idx == sync_status_pkg::IDX_IRQ_MASK)); // see [R11]

  // Read decode
  assign rd_idx        = s_axi_araddr[11:2];
  assign rd_align      = (s_axi_araddr[1:0] == 2'h0);
  assign rd_status_clr = ar_hs && rd_align && (rd_idx == sync_status_pkg::IDX_IRQ_STATUS);
  always_comb begin
    rd_byte  = 8'h00;
    rd_known = rd_align;
    unique case (rd_idx)
      sync_status_pkg::IDX_ADJ_DELAY:  rd_byte = applied_ff; // see [R10]
      sync_status_pkg::IDX_EVAL:       rd_byte = {7'h00, eval_active_flag}; // see [R01]
      sync_status_pkg::IDX_FSM:        rd_byte = {busy_flag, state_err_flag, 2'h0,
                                                  state_ff}; // see [R02] see [R03] see [R04]
      sync_status_pkg::IDX_LOCK:       rd_byte = {sysref_locked_flag, 7'h00}; // see [R05]
      sync_status_pkg::IDX_LOCK_COUNTER:   rd_byte = {4'h0, lock_counter_ff}; // see [R06]
      sync_status_pkg::IDX_DELAY_COUNTER:  rd_byte = period_cnt_ff; // see [R07]
      sync_status_pkg::IDX_SAMPLE:     rd_byte = sample_ff; // see [R07]
      sync_status_pkg::IDX_PHASE:      rd_byte = {6'h00, phase_ff}; // see [R07]
      sync_status_pkg::IDX_CTRL:       rd_byte = {enable_ff, 2'h0, relock_ff, thresh_ff};
      sync_status_pkg::IDX_IRQ_STATUS: rd_byte = {5'h00, irq_status};
      sync_status_pkg::IDX_IRQ_MASK:   rd_byte = {5'h00, mask_ff};
      default:                         rd_known = 1'b0;
    endcase
  end

  // Write channel holding and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wbyte_ff   <= '0;
      wlane_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= sync_status_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) awaddr_ff <= s_axi_awaddr;
      if (w_hs) begin
        wbyte_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_known ? sync_status_pkg::RESP_OKAY : sync_status_pkg::RESP_SLVERR;
      end else begin
        aw_held_ff <= aw_held_ff || aw_hs;
        w_held_ff  <= w_held_ff || w_hs;
        if (s_axi_bready) bvalid_ff <= 1'b0;
      end
    end
  end

  // Writable control words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_ff <= 1'b0;
      relock_ff <= 1'b0;
      thresh_ff <= sync_status_pkg::THRESH_RESET;
      mask_ff   <= '0;
    end else begin
      if (wr_ctrl) begin
        enable_ff <= wr_byte[sync_status_pkg::BIT_ENABLE];
        relock_ff <= wr_byte[sync_status_pkg::BIT_RELOCK];
        thresh_ff <= wr_byte[3:0];
      end
      if (wr_mask) mask_ff <= wr_byte[2:0];
    end
  end

  // Read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= sync_status_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_known ? {24'h000000, rd_byte} : 32'h00000000;
      rresp_ff  <= rd_known ? sync_status_pkg::RESP_OKAY : sync_status_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ---------------------------------------------------------------
  // Interrupt bank
  // ---------------------------------------------------------------
  sticky_irq #(
    .WIDTH (sync_status_pkg::IRQ_WIDTH)
  ) u_sticky_irq (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .event_in      (events),
    .clear_on_read (rd_status_clr),
    .mask_in       (mask_ff),
    .status_out    (irq_status),
    .irq           (irq)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence rd_of(logic [9:0] idx);
    ar_hs && rd_align && (rd_idx == idx);
  endsequence

  eval_start_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R01]
    enable_ff && state_ff == sync_status_pkg::ST_IDLE |=> eval_active_flag [*1] ##0 busy_flag)
    else $error("evaluation did not start after enable");
  busy_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R02]
    rd_of(sync_status_pkg::IDX_FSM) |=> s_axi_rvalid && (s_axi_rdata[7] == $past(busy_flag)))
    else $error("busy bit read wrong");
  err_cause_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R03]
    $rose(state_err_flag) |-> $past(period_full) || ($past(lose_lock) && !$past(relock_ff)))
    else $error("state error raised without cause");
  state_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R04]
    rd_of(sync_status_pkg::IDX_FSM) |=> (s_axi_rdata[5:4] == 2'h0) &&
    (s_axi_rdata[3:0] == $past(state_ff)))
    else $error("state code read wrong");
  lock_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R05]
    rd_of(sync_status_pkg::IDX_LOCK) |=> s_axi_rdata[7] == $past(sysref_locked_flag))
    else $error("lock bit read wrong");
  cnt_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R06]
    rd_of(sync_status_pkg::IDX_LOCK_COUNTER) |=> s_axi_rdata[7:0] == {4'h0, $past(lock_counter_ff)})
    else $error("lock counter read wrong");
  delay_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R07]
    rd_of(sync_status_pkg::IDX_DELAY_COUNTER) |=> s_axi_rdata[7:0] == $past(period_cnt_ff))
    else $error("delay count read wrong");
  lock_thresh_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R08]
    $rose(sysref_locked_flag) |-> ({1'b0, $past(lock_counter_ff)} + 5'h01) >= {1'b0, $past(thresh_ff)})
    else $error("lock declared before threshold");
  relock_path_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R09]
    lose_lock && enable_ff |=> (state_ff == (($past(relock_ff)) ? sync_status_pkg::ST_SEEK
                                                                : sync_status_pkg::ST_ERROR)))
    else $error("wrong reaction to lost lock");
  adj_take_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R10]
    $rose(sysref_locked_flag) |-> applied_ff == $past(period_cnt_ff))
    else $error("adjust delay not taken at lock");
  ro_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R11]
    do_write && wr_align && (wr_idx == sync_status_pkg::IDX_FSM) |=> s_axi_bvalid &&
    (s_axi_bresp == sync_status_pkg::RESP_OKAY) && $stable(thresh_ff) && $stable(mask_ff))
    else $error("status write had an effect");

endmodule : sync_status_readback

// [sysref_source.sv]
`timescale 1ns/1ps
module sysref_source (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       run,
  input  wire logic [7:0] period,
  // Pulse pin
  output logic            pulse
);
  logic [7:0] cnt_ff;
  // Fixed period; pin held low when stopped
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || cnt_ff == period - 8'h01) cnt_ff <= 8'h00;
    else cnt_ff <= cnt_ff + 8'h01;
  end
  assign pulse = run && (cnt_ff < 8'h02);
endmodule : sysref_source

// [tb_sync_status_readback.sv]
`timescale 1ns/1ps
module tb_sync_status_readback;
  logic        aclk, aresetn, run, irq, sref;
  logic [11:0] awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  bresp, rresp, rr;
  logic [3:0]  wstrb;
  logic [7:0]  period;
  int          num_errors, cmp_count, cyc;

  sysref_source src (.aclk(aclk), .aresetn(aresetn), .run(run), .period(period), .pulse(sref));
  sync_status_readback DUT (.aclk(aclk), .aresetn(aresetn), .sysref_in(sref),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq));

  // Clock, 40 ns period
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Hang guard; tests take about 1000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Write one word; handshakes judged at the falling edge, released after the rising one
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic       aw_t;
    logic       w_t;
    logic       b_t;
    logic [1:0] br;
    awaddr  <= {idx, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t  = wvalid && wready;
      b_t  = bvalid;
      br   = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
    @(posedge aclk);
    check({30'h0, br}, 32'h0);
  endtask : wr

  // Read one word into rv and its response into rr
  task automatic rd(input logic [9:0] idx);
    logic ar_t;
    logic r_t;
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t  = rvalid;
      rv   = rdata;
      rr   = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Read one word and check data and response
  task automatic rc(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    rd(idx);
    check(rv, exp);
    check({30'h0, rr}, {30'h0, er});
  endtask : rc

  // Bounded wait for the interrupt line
  task automatic wait_irq;
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 600 && !seen; n++) begin
      @(negedge aclk);
      seen = (irq === 1'b1);
    end
    @(posedge aclk);
    check({31'h0, seen}, 32'h1);
  endtask : wait_irq

  task automatic t_reset;
    rc(sync_status_pkg::IDX_EVAL, 32'h0);
    rc(sync_status_pkg::IDX_FSM, 32'h0);
    rc(sync_status_pkg::IDX_LOCK, 32'h0);
    rc(sync_status_pkg::IDX_LOCK_COUNTER, 32'h0);
    rc(sync_status_pkg::IDX_SAMPLE, 32'h0);
    rc(10'h0B9, 32'h0, 2'h2);
    wr(sync_status_pkg::IDX_FSM, 8'hFF);
    rc(sync_status_pkg::IDX_FSM, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_lock;
    wr(sync_status_pkg::IDX_IRQ_MASK, 8'h07);
    wr(sync_status_pkg::IDX_CTRL, 8'h84);
    run <= 1'b1;
    repeat (50) @(posedge aclk);
    rc(sync_status_pkg::IDX_FSM, 32'h83);
    rc(sync_status_pkg::IDX_LOCK, 32'h0);
    rc(sync_status_pkg::IDX_EVAL, 32'h1);
    wait_irq();
    rc(sync_status_pkg::IDX_LOCK, 32'h80);
    rc(sync_status_pkg::IDX_FSM, 32'h02);
    rc(sync_status_pkg::IDX_ADJ_DELAY, {24'h0, period - 8'h01});
    rc(sync_status_pkg::IDX_PHASE, {30'h0, period[1:0] - 2'h1});
    rc(sync_status_pkg::IDX_LOCK_COUNTER, 32'h0);
    rd(sync_status_pkg::IDX_DELAY_COUNTER);
    check({31'h0, rv < {24'h0, period}}, 32'h1);
    rc(sync_status_pkg::IDX_IRQ_STATUS, 32'h1);
    rc(sync_status_pkg::IDX_IRQ_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("lock test done");
  endtask : t_lock

  task automatic t_lost;
    wr(sync_status_pkg::IDX_IRQ_MASK, 8'h01);
    run <= 1'b0;
    repeat (300) @(posedge aclk);
    check({31'h0, irq}, 32'h0);                // Masked events keep the line low
    rc(sync_status_pkg::IDX_FSM, 32'h46);
    rc(sync_status_pkg::IDX_LOCK, 32'h0);
    rc(sync_status_pkg::IDX_SAMPLE, 32'h0);
    rc(sync_status_pkg::IDX_IRQ_STATUS, 32'h6);
    $display("lost test done");
  endtask : t_lost

  task automatic t_relock;
    wr(sync_status_pkg::IDX_CTRL, 8'h00);
    rc(sync_status_pkg::IDX_EVAL, 32'h0);
    wr(sync_status_pkg::IDX_CTRL, 8'h92);
    run <= 1'b1;
    wait_irq();
    rc(sync_status_pkg::IDX_IRQ_STATUS, 32'h1);
    run <= 1'b0;
    repeat (300) @(posedge aclk);
    rc(sync_status_pkg::IDX_FSM, 32'h81);
    rc(sync_status_pkg::IDX_IRQ_STATUS, 32'h2);
    run <= 1'b1;
    wait_irq();
    $display("relock test done");
  endtask : t_relock

  // Main sequence
  initial begin
    {aresetn, run, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    period = 8'h14;
    num_errors = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_lock();
    t_lost();
    t_relock();
    give_verdict();
  end
endmodule : tb_sync_status_readback
